// ==== logic/aoc_top.sv ====
// Purpose: pin-driven output configuration of a 16-bit converter digital side
// Assumes: result arrives as a 16-bit word with a one-cycle valid pulse
// Notes:   all pins are taken as synchronous to mclk; outputs are registered
//
// Functional notes
// - byte order select high swaps bus bytes
// - coding select low inverts msb, twos complement
// - both mode pins high: wideband mode
// - fast high, low power low: fast mode
// - both mode pins low: normal mode
// - low power high, fast low: low power
// - serial port selected releases unused data lines
// - port select low: parallel result output
// - data lines zero, one are outputs only
// - parallel mode drives data lines two, three
// - master read after convert: lines two, three divide
// - other serial modes release lines two, three
// - divider codes give 8/16/32/64 ns periods
// - clock source low master, high slave
// - read timing low: read after conversion
`timescale 1ns/1ps

module aoc_top (
    input  wire logic                         mclk,         // system clock, 250 MHz
    input  wire logic                         srst,         // sync reset, active high
    input  wire aoc_pkg::aoc_cfg_s            cfg,          // configuration pins
    input  wire logic [aoc_pkg::DATA_W-1:0]   result,       // finished conversion word
    input  wire logic                         result_valid, // pulse: result is complete
    input  wire logic                         cs_n,         // serial chip select, low
    input  wire logic                         ext_sclk,     // slave serial clock level
    input  wire logic [aoc_pkg::DATA_W-1:0]   d_in,         // data pins, input side
    output logic [aoc_pkg::DATA_W-1:0]        d_out,        // data pins, output side
    output logic [aoc_pkg::DATA_W-1:0]        d_oe,         // data pins, high drives
    output logic                              sclk_out,     // master serial clock
    output logic                              sclk_oe,      // high while sclk driven
    output logic                              sdout,        // serial data out
    output logic                              sync,         // high while word shifts
    output aoc_pkg::aoc_mode_e                conv_mode     // current conversion mode
);

    // ************************************************************
    // serial shift states
    // ************************************************************
    typedef enum logic [1:0] {
        AOC_SH_IDLE  = 2'h1,                                // waiting for a result
        AOC_SH_SHIFT = 2'h2                                 // bits going out
    } aoc_sh_e;

    // ************************************************************
    // declarations
    // ************************************************************
    aoc_pkg::aoc_cfg_s          cfg_q;                      // registered pins
    aoc_pkg::aoc_cfg_s          next_cfg_q;                 // next value
    aoc_pkg::aoc_mode_e         next_conv_mode;             // next mode
    logic [aoc_pkg::DATA_W-1:0] hold_word;                  // held finished result
    logic [aoc_pkg::DATA_W-1:0] next_hold_word;             // next value
    logic [aoc_pkg::DATA_W-1:0] next_d_out;                 // next bus value
    logic [aoc_pkg::DATA_W-1:0] next_d_oe;                  // next enables
    logic [aoc_pkg::DATA_W-1:0] shift_reg;                  // serial shifter
    logic [aoc_pkg::DATA_W-1:0] next_shift_reg;             // next value
    logic [aoc_pkg::CNT_W-1:0]  bit_cnt;                    // bits still to send
    logic [aoc_pkg::CNT_W-1:0]  next_bit_cnt;               // next value
    aoc_sh_e                    sh_state;                   // serial state
    aoc_sh_e                    next_sh_state;              // next state
    logic                       next_sclk_oe;               // next enable
    logic                       next_sdout;                 // next data bit
    logic                       next_sync;                  // next frame flag
    logic                       ext_sclk_q;                 // last slave clock level
    logic [aoc_pkg::DIV_W-1:0]  div_code;                   // divider in use
    logic [aoc_pkg::DIV_W-1:0]  next_div_code;              // next value
    logic                       div_sclk;                   // generated clock level
    logic                       div_fall;                   // generated falling edge
    logic                       serial_mode;                // serial port selected
    logic                       master_mode;                // internal clock in use
    logic                       master_rac;                 // master read after convert
    logic                       ext_rise;                   // slave clock rising edge
    logic                       shift_tick;                 // advance one serial bit
    logic                       run_div;                    // generator enable

    // ************************************************************
    // decode of the registered configuration
    // ************************************************************
    always_comb begin
        serial_mode = cfg_q.port_type_select;
        master_mode = serial_mode && !cfg_q.clock_source_select;
        master_rac  = master_mode && !cfg_q.read_timing_select;
        ext_rise    = ext_sclk && !ext_sclk_q;
        // park at the last fall, so no extra rising edge follows the word
        run_div     = master_mode && (sh_state == AOC_SH_SHIFT)
                      && !(div_fall && (bit_cnt == 5'h01));
        // master shifts on its own falling edge, slave on the outside edge
        shift_tick  = master_mode ? div_fall : (ext_rise && !cs_n);
    end

    // ************************************************************
    // internal serial clock generator
    // ************************************************************
    aoc_sclk_div aoc_sclk_div_inst (
        .mclk      (mclk),
        .srst      (srst),
        .run       (run_div),
        .div_code  (div_code),
        .sclk      (div_sclk),
        .fall_tick (div_fall)
    );

    // ************************************************************
    // configuration, mode and held result
    // ************************************************************
    // pins are registered once so every path sees one consistent setting
    always_comb begin
        next_cfg_q     = cfg;
        next_conv_mode = aoc_pkg::decode_mode(cfg_q.fast_mode_select,
                                              cfg_q.low_power_mode_select);
        next_hold_word = hold_word;
        if (result_valid) begin                             // keep the completed word
            next_hold_word = result;
        end
        next_div_code = div_code;
        if (sh_state == AOC_SH_IDLE) begin                  // only change between words
            if (master_rac) begin                           // divider read from the bus
                next_div_code = d_in[aoc_pkg::DIV_MSB_POS:aoc_pkg::DIV_LSB_POS];
            end else begin                                  // fastest clock otherwise
                next_div_code = '0;
            end
        end
    end

    // ************************************************************
    // parallel bus and pin directions
    // ************************************************************
    always_comb begin
        next_d_out = d_out;
        next_d_oe  = aoc_pkg::OE_OUT_ONLY;
        if (!serial_mode) begin
            // coding first, then byte order, on the held result
            next_d_out = aoc_pkg::apply_order(
                             aoc_pkg::apply_coding(hold_word, cfg_q.output_coding_select),
                             cfg_q.byte_order_select);
            next_d_oe  = aoc_pkg::OE_ALL;
        end else begin
            // lines two and three stay released: inputs in master read
            // after convert, plain high impedance in every other mode
            next_d_out = aoc_pkg::WORD_ZERO;
            next_d_oe  = aoc_pkg::OE_OUT_ONLY;
        end
    end

    // ************************************************************
    // serial shifter
    // ************************************************************
    // byte order does not apply here: the serial word always leaves msb first
    always_comb begin
        next_sh_state  = sh_state;
        next_shift_reg = shift_reg;
        next_bit_cnt   = bit_cnt;
        next_sdout     = sdout;
        next_sync      = sync;
        next_sclk_oe   = master_mode;
        case (sh_state)
            AOC_SH_IDLE: begin
                next_sync = 1'b0;
                if (result_valid && serial_mode) begin      // new result to send
                    next_shift_reg = aoc_pkg::apply_coding(result,
                                                           cfg_q.output_coding_select);
                    next_bit_cnt   = aoc_pkg::BITS_PER_WORD;
                    next_sdout     = next_shift_reg[aoc_pkg::MSB_POS];
                    next_sync      = 1'b1;
                    next_sh_state  = AOC_SH_SHIFT;
                end
            end
            AOC_SH_SHIFT: begin
                if (!serial_mode) begin                     // port changed: abandon word
                    next_sync     = 1'b0;
                    next_sdout    = 1'b0;
                    next_sh_state = AOC_SH_IDLE;
                end else if (shift_tick) begin
                    next_shift_reg = {shift_reg[aoc_pkg::DATA_W-2:0], 1'b0};
                    next_bit_cnt   = bit_cnt - 5'h01;
                    next_sdout     = shift_reg[aoc_pkg::MSB_POS-1];
                    if (bit_cnt == 5'h01) begin             // last bit done
                        next_sync     = 1'b0;
                        next_sdout    = 1'b0;
                        next_bit_cnt  = aoc_pkg::CNT_ZERO;
                        next_sh_state = AOC_SH_IDLE;
                    end
                end
            end
            default: begin                                  // illegal code: recover
                next_sync     = 1'b0;
                next_sh_state = AOC_SH_IDLE;
            end
        endcase
    end

    // ************************************************************
    // registers only
    // ************************************************************
    always_ff @(posedge mclk) begin
        if (srst) begin
            cfg_q      <= aoc_pkg::CFG_RESET;
            conv_mode  <= aoc_pkg::MODE_RESET;
            hold_word  <= aoc_pkg::WORD_ZERO;
            d_out      <= aoc_pkg::WORD_ZERO;
            d_oe       <= aoc_pkg::OE_NONE;
            div_code   <= '0;
            sh_state   <= AOC_SH_IDLE;
            shift_reg  <= aoc_pkg::WORD_ZERO;
            bit_cnt    <= aoc_pkg::CNT_ZERO;
            sdout      <= 1'b0;
            sync       <= 1'b0;
            sclk_oe    <= 1'b0;
            sclk_out   <= 1'b0;
            ext_sclk_q <= 1'b0;
        end else begin
            cfg_q      <= next_cfg_q;
            conv_mode  <= next_conv_mode;
            hold_word  <= next_hold_word;
            d_out      <= next_d_out;
            d_oe       <= next_d_oe;
            div_code   <= next_div_code;
            sh_state   <= next_sh_state;
            shift_reg  <= next_shift_reg;
            bit_cnt    <= next_bit_cnt;
            sdout      <= next_sdout;
            sync       <= next_sync;
            sclk_oe    <= next_sclk_oe;
            sclk_out   <= div_sclk;                         // one cycle behind generator
            ext_sclk_q <= ext_sclk;
        end
    end

endmodule : aoc_top

// ==== logic/aoc_pkg.sv ====
// Purpose: shared constants, types and helpers for the converter output mode logic
// Assumes: one 250 MHz clock, all pin inputs already synchronous to it
// Notes:   every count of clock cycles is derived here from a time in ns

// ****************************************************************
// package
// ****************************************************************
package aoc_pkg;

    // ************************************************************
    // clock and widths
    // ************************************************************
    localparam int unsigned CLK_PERIOD_NS = 4;          // mclk period at 250 MHz
    localparam int unsigned DATA_W        = 16;         // result and data bus width
    localparam int unsigned BYTE_W        = 8;          // one byte lane
    localparam int unsigned MSB_POS       = 15;         // position of the result msb
    localparam int unsigned DIV_W         = 2;          // serial clock divider code width
    localparam int unsigned CNT_W         = 5;          // shift bit counter width
    localparam int unsigned HALF_W        = 4;          // half period counter width

    // ************************************************************
    // data bus lane positions
    // ************************************************************
    localparam int unsigned DIV_LSB_POS   = 2;          // data line carrying divider bit 0
    localparam int unsigned DIV_MSB_POS   = 3;          // data line carrying divider bit 1
    localparam logic [DATA_W-1:0] OE_OUT_ONLY = 16'h0003; // lines 0 and 1, always outputs
    localparam logic [DATA_W-1:0] OE_ALL      = 16'hffff; // every line driven
    localparam logic [DATA_W-1:0] OE_NONE     = 16'h0000; // every line released
    localparam logic [DATA_W-1:0] WORD_ZERO   = 16'h0000; // cleared word
    localparam logic [CNT_W-1:0]  BITS_PER_WORD = 5'h10;  // serial bits per result
    localparam logic [CNT_W-1:0]  CNT_ZERO    = 5'h00;    // cleared bit counter

    // ************************************************************
    // internal serial clock minimum periods, ns, per divider code
    // ************************************************************
    localparam int unsigned SCLK_MIN_NS_0 = 8;          // code 00
    localparam int unsigned SCLK_MIN_NS_1 = 16;         // code 01
    localparam int unsigned SCLK_MIN_NS_2 = 32;         // code 10
    localparam int unsigned SCLK_MIN_NS_3 = 64;         // code 11

    // least time: round up to whole cycles, never below one
    function automatic int unsigned ns_to_cyc_up(input int unsigned ns);
        int unsigned c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : ns_to_cyc_up

    // half period in cycles, never below one
    function automatic logic [HALF_W-1:0] half_cyc(input int unsigned ns);
        int unsigned h;
        h = ns_to_cyc_up(ns) / 2;
        return (h < 1) ? HALF_W'(1) : HALF_W'(h);
    endfunction : half_cyc

    localparam logic [HALF_W-1:0] SCLK_HALF_0 = half_cyc(SCLK_MIN_NS_0); // 1 cycle
    localparam logic [HALF_W-1:0] SCLK_HALF_1 = half_cyc(SCLK_MIN_NS_1); // 2 cycles
    localparam logic [HALF_W-1:0] SCLK_HALF_2 = half_cyc(SCLK_MIN_NS_2); // 4 cycles
    localparam logic [HALF_W-1:0] SCLK_HALF_3 = half_cyc(SCLK_MIN_NS_3); // 8 cycles
    localparam logic [HALF_W-1:0] HALF_ONE    = 4'h1;   // counter reload point

    // ************************************************************
    // types
    // ************************************************************
    // conversion mode, one-hot
    typedef enum logic [3:0] {
        AOC_MODE_NORMAL    = 4'h1,                      // full accuracy at any rate
        AOC_MODE_LOW_POWER = 4'h2,                      // power follows sample rate
        AOC_MODE_FAST      = 4'h4,                      // max throughput, min rate needed
        AOC_MODE_WIDEBAND  = 4'h8                       // max throughput, better linearity
    } aoc_mode_e;

    localparam aoc_mode_e MODE_RESET = AOC_MODE_NORMAL; // mode after reset

    // configuration pins, grouped
    typedef struct packed {
        logic fast_mode_select;                         // high selects a fast mode
        logic low_power_mode_select;                    // high selects low power or wideband
        logic byte_order_select;                        // high swaps bytes on the bus
        logic output_coding_select;                     // high straight binary
        logic port_type_select;                         // high serial, low parallel
        logic clock_source_select;                      // low master, high slave
        logic read_timing_select;                       // low read after convert
    } aoc_cfg_s;

    localparam aoc_cfg_s CFG_RESET = '0;                // configuration after reset

    // mode decode from the two mode pins
    function automatic aoc_mode_e decode_mode(input logic fast, input logic low_pwr);
        if (fast && low_pwr) begin
            return AOC_MODE_WIDEBAND;
        end else if (fast) begin
            return AOC_MODE_FAST;
        end else if (low_pwr) begin
            return AOC_MODE_LOW_POWER;
        end
        return AOC_MODE_NORMAL;
    endfunction : decode_mode

    // coding: low selects twos complement by inverting the msb
    function automatic logic [DATA_W-1:0] apply_coding(input logic [DATA_W-1:0] w,
                                                       input logic straight);
        logic [DATA_W-1:0] r;
        r = w;
        r[MSB_POS] = straight ? w[MSB_POS] : ~w[MSB_POS];
        return r;
    endfunction : apply_coding

    // byte order: high puts the low byte on the upper lines
    function automatic logic [DATA_W-1:0] apply_order(input logic [DATA_W-1:0] w,
                                                      input logic swap);
        return swap ? {w[BYTE_W-1:0], w[DATA_W-1:BYTE_W]} : w;
    endfunction : apply_order

endpackage : aoc_pkg

// ==== logic/aoc_sclk_div.sv ====
// Purpose: internal serial clock generator with four selectable periods
// Assumes: divider code stays stable while run is high
// Notes:   the clock idles low; fall_tick marks where new data is launched
`timescale 1ns/1ps

module aoc_sclk_div (
    input  wire logic                     mclk,      // system clock
    input  wire logic                     srst,      // sync reset, active high
    input  wire logic                     run,       // high while a word is shifted in master mode
    input  wire logic [aoc_pkg::DIV_W-1:0] div_code, // selected divider code
    output logic                          sclk,      // generated serial clock level
    output logic                          fall_tick  // one-cycle pulse at falling edge
);

    // ************************************************************
    // state
    // ************************************************************
    logic [aoc_pkg::HALF_W-1:0] half_cnt;            // cycles left in this half
    logic [aoc_pkg::HALF_W-1:0] next_half_cnt;       // next value
    logic                       next_sclk;           // next clock level
    logic                       next_fall_tick;      // next pulse
    logic [aoc_pkg::HALF_W-1:0] half_len;            // half period for the code

    // half period lookup, cycles at mclk
    always_comb begin
        case (div_code)
            2'h0:    half_len = aoc_pkg::SCLK_HALF_0;
            2'h1:    half_len = aoc_pkg::SCLK_HALF_1;
            2'h2:    half_len = aoc_pkg::SCLK_HALF_2;
            default: half_len = aoc_pkg::SCLK_HALF_3;
        endcase
    end

    // next values: toggle at the end of each half, hold low when idle
    always_comb begin
        next_half_cnt  = half_cnt;
        next_sclk      = sclk;
        next_fall_tick = 1'b0;
        if (!run) begin                                // idle: clock parked low
            next_half_cnt = half_len;
            next_sclk     = 1'b0;
        end else if (half_cnt <= aoc_pkg::HALF_ONE) begin
            next_half_cnt  = half_len;
            next_sclk      = ~sclk;
            next_fall_tick = sclk;                     // high going low
        end else begin
            next_half_cnt = half_cnt - aoc_pkg::HALF_ONE;
        end
    end

    // registers only
    always_ff @(posedge mclk) begin
        if (srst) begin
            half_cnt  <= aoc_pkg::SCLK_HALF_0;
            sclk      <= 1'b0;
            fall_tick <= 1'b0;
        end else begin
            half_cnt  <= next_half_cnt;
            sclk      <= next_sclk;
            fall_tick <= next_fall_tick;
        end
    end

endmodule : aoc_sclk_div

// ==== testbench/aoc_assertions.sv ====
// Purpose: port level checks for aoc_top
// Assumes: one clock, synchronous reset
// Notes:   checks wait three edges after reset so reset values never fire them
`timescale 1ns/1ps
module aoc_assertions (
    input logic               mclk,         // clock
    input logic               srst,         // reset
    input aoc_pkg::aoc_cfg_s  cfg,          // pins
    input logic [15:0]        result,       // word
    input logic               result_valid, // pulse
    input logic [15:0]        d_out,        // bus
    input logic [15:0]        d_oe,         // enables
    input aoc_pkg::aoc_mode_e conv_mode     // mode
);
    // ****************
    // helper logic
    // ****************
    logic [1:0]  age;      // edges since reset, saturating
    logic [1:0]  next_age; // next count
    logic [15:0] exp_w;    // coded and ordered word
    logic [1:0]  mp;       // mode pins
    logic        ok;       // settled after reset
    // expected word built by hand, not from the design helpers
    always_comb begin
        next_age = (age == 2'h3) ? age : age + 2'h1;
        exp_w = result ^ {~cfg.output_coding_select, 15'h0000};
        if (cfg.byte_order_select) begin
            exp_w = {exp_w[7:0], exp_w[15:8]};
        end
        mp = {cfg.fast_mode_select, cfg.low_power_mode_select};
        ok = (age == 2'h3);
    end
    always_ff @(posedge mclk) begin
        age <= srst ? 2'h0 : next_age;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    property p_word; (ok && result_valid && !cfg.port_type_select && $stable(cfg))
        ##1 $stable(cfg)[*2] |-> d_out == $past(exp_w, 2); endproperty
    a_word: assert property (p_word) else $error("parallel word wrong");
    property p_ser; (ok && cfg.port_type_select)[*3] |-> d_oe == 16'h0003 && d_out == 16'h0000;
    endproperty
    a_ser: assert property (p_ser) else $error("serial lines not released");
    property p_par; (ok && !cfg.port_type_select)[*3] |-> d_oe == 16'hffff; endproperty
    a_par: assert property (p_par) else $error("parallel lines not driven");
    property p_low2; ok |-> d_oe[1:0] == 2'h3; endproperty
    a_low2: assert property (p_low2) else $error("lines 0 1 released");
    property p_wide; (ok && mp == 2'h3)[*3] |-> conv_mode == 4'h8; endproperty
    a_wide: assert property (p_wide) else $error("mode not wideband");
    property p_fast; (ok && mp == 2'h2)[*3] |-> conv_mode == 4'h4; endproperty
    a_fast: assert property (p_fast) else $error("mode not fast");
    property p_norm; (ok && mp == 2'h0)[*3] |-> conv_mode == 4'h1; endproperty
    a_norm: assert property (p_norm) else $error("mode not normal");
    property p_lowp; (ok && mp == 2'h1)[*3] |-> conv_mode == 4'h2; endproperty
    a_lowp: assert property (p_lowp) else $error("mode not low power");
    c_swap: cover property (result_valid && cfg.byte_order_select && !cfg.port_type_select);
    c_ser: cover property (result_valid && cfg.port_type_select);
    c_wide: cover property (ok && mp == 2'h3);
endmodule : aoc_assertions

// ==== testbench/aoc_host_model.sv ====
// Purpose: host that reads serial words from the converter
// Assumes: master clock sampled on mclk; slave clock made here
// Notes:   slave clock stands still low outside frames
`timescale 1ns/1ps
module aoc_host_model (
    input  logic        mclk,     // clock
    input  logic        slave,    // host makes the clock
    input  logic        sclk_out, // master clock
    input  logic        sdout,    // serial data
    input  logic        sync,     // frame marker
    output logic        cs_n,     // select, low
    output logic        ext_sclk, // slave clock
    output logic [15:0] word,     // last 16 bits
    output int          per       // last master period, cycles
);
    int   cnt = 0;       // cycles since last rise
    logic sclk_q = 1'b0; // last master clock sample
    assign cs_n = ~slave;
    initial word = 16'h0000;
    initial per = 0;
    initial ext_sclk = 1'b0;
    // sample one cycle after each master rise, before each slave rise; slow slave clock hides sync delay
    always @(posedge mclk) begin
        sclk_q <= sclk_out;
        cnt <= cnt + 1;
        if (sclk_out && !sclk_q) begin
            word <= {word[14:0], sdout};
            per <= cnt + 1;
            cnt <= 0;
        end
        if (slave && sync) begin
            if (cnt % 4 == 3) begin
                if (!ext_sclk) word <= {word[14:0], sdout};
                ext_sclk <= ~ext_sclk;
            end
        end else ext_sclk <= 1'b0;
    end
endmodule : aoc_host_model

// ==== testbench/adc_output_mode_config_test.sv ====
// Purpose: self checking bench for aoc_top
// Assumes: inputs change on the falling edge
// Notes:   expected values computed here from coding and order
`timescale 1ns/1ps
module adc_output_mode_config_test;
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin err_total++; \
    $display("ERROR %s exp %h got %h", n, e, s); end end
    logic mclk = 0, srst = 1, result_valid = 0, slave = 0, cs_n, ext_sclk, sclk_out, sclk_oe;
    logic sdout, sync;
    logic [15:0] result = 0, d_out, d_oe, w, e, word;
    logic [1:0] div = 0; // host divider code
    logic [15:0] q[$]; // model results, oldest first
    aoc_pkg::aoc_cfg_s cfg = '0;
    aoc_pkg::aoc_mode_e conv_mode;
    int i, per, seed = 13, err_total = 0, tests_run = 0;
    // released lines read back inverted; host drives lines 3:2
    wire logic [15:0] d_in = (d_oe & d_out) | (~d_oe & {~d_out[15:4], div, 2'h0});
    aoc_top aoc_top_inst (.mclk(mclk), .srst(srst), .cfg(cfg), .result(result),
        .result_valid(result_valid), .cs_n(cs_n), .ext_sclk(ext_sclk), .d_in(d_in),
        .d_out(d_out), .d_oe(d_oe), .sclk_out(sclk_out), .sclk_oe(sclk_oe), .sdout(sdout),
        .sync(sync), .conv_mode(conv_mode));
    aoc_host_model aoc_host_model_inst (.mclk(mclk), .slave(slave), .sclk_out(sclk_out),
        .sdout(sdout), .sync(sync), .cs_n(cs_n), .ext_sclk(ext_sclk), .word(word), .per(per));
    initial forever #2 mclk = ~mclk;
    task pulse(input logic [15:0] v); // frequent starts keep rate up
        @(negedge mclk) result = v;
        result_valid = 1'b1;
        @(negedge mclk) result_valid = 1'b0;
    endtask : pulse
    task close_out;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : close_out
    initial begin
        #80000 err_total++;
        close_out;
    end
    initial begin
        repeat (16) @(negedge mclk);
        srst = 0;
        for (i = 0; i < 4; i++) begin
            {cfg.fast_mode_select, cfg.low_power_mode_select} = 2'(i);
            repeat (3) @(negedge mclk);
            `CHK("conv_mode", 4'(4'h1 << i), conv_mode)
        end
        $display("modes done");
        for (i = 0; i < 8; i++) begin
            w = 16'($random(seed));
            {cfg.byte_order_select, cfg.output_coding_select} = w[1:0];
            e = w ^ {~w[0], 15'h0000}; // model: coding, then order
            if (w[1]) e = {e[7:0], e[15:8]};
            q.push_back(e);
            repeat (2) @(negedge mclk);
            pulse(w);
            repeat (2) @(negedge mclk);
            e = q.pop_front();
            `CHK("d_out", e, d_out)
        end
        $display("parallel done");
        cfg.port_type_select = 1'b1;
        for (i = 0; i < 6; i++) begin
            w = 16'($random(seed));
            {cfg.byte_order_select, cfg.output_coding_select} = w[1:0];
            cfg.read_timing_select = (i == 4);
            {slave, cfg.clock_source_select} = {2{i == 5}};
            div = (i > 3) ? 2'h3 : 2'(i);
            repeat (3) @(negedge mclk);
            q.push_back(w ^ {~w[0], 15'h0000}); // second start refused
            pulse(w);
            pulse(~w);
            repeat (3000) if (sync) @(negedge mclk);
            e = q.pop_front();
            `CHK("word", e, word)
            `CHK("d_oe", 16'h0003, d_oe)
            `CHK("sclk_oe", i != 5, sclk_oe)
            if (i < 5) `CHK("period", (i < 4) ? 2 << i : 2, per)
        end
        $display("serial done");
        close_out;
    end
endmodule : adc_output_mode_config_test
bind aoc_top aoc_assertions aoc_assertions_inst (.mclk(mclk), .srst(srst), .cfg(cfg),
    .result(result), .result_valid(result_valid), .d_out(d_out), .d_oe(d_oe),
    .conv_mode(conv_mode));
